// >>> inc/efuse_core_consts.svh
`ifndef EFUSE_CORE_CONSTS_SVH
`define EFUSE_CORE_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_ID_MAIN 3'h0
`define IDX_ID_AUX 3'h1
`define IDX_CORE_VSEL 3'h2
`define IDX_AUX_VSEL 3'h3
`define IDX_CONTROL 3'h4
`define IDX_STATUS_A 3'h5
`define IDX_STATUS_B 3'h6
`define IDX_LAST 3'h6

// reset values
`define RST_CORE_VSEL 6'h22
`define RST_AUX_VSEL 5'h13
`define RST_CORE_MV 11'h3ac

// field positions in the aux select register
`define AUX_UNLOCK_BIT 5

// field positions in the control register
`define CTL_FW_POWER_EN 7
`define CTL_MON_GAIN 6
`define CTL_AUX_PWM 5
`define CTL_CORE_PWM 4
`define CTL_DEGLITCH 3
`define CTL_MON_EN 2
`define CTL_MON_HOLD 1
`define CTL_CORE_DIS 0

// field positions in status B
`define STB_POWER_DIS 3

// core output voltage code mapping in millivolts
`define CORE_MV_BASE 11'h302
`define CORE_MV_STEP 11'h005

`endif

// >>> inc/efuse_core_pkg.sv
package efuse_core_pkg;

  // digital comparator results from the analog front end
  typedef struct packed {
    logic inputOk;
    logic overVoltage;
    logic overTemp;
    logic tempCool;
    logic tempWarn;
    logic underVoltage;
    logic overCurrent;
    logic shortDetect;
  } fuse_sense_t;

  typedef struct packed {
    logic on;
    logic clamp;
    logic shortLimit;
  } fuse_ctrl_t;

  typedef struct packed {
    logic underVoltage33;
    logic overCurrent33;
    logic underVoltage09;
    logic overCurrent09;
  } rail_sense_t;

  // core regulator sequence, gray coded
  typedef enum logic [1:0] {
    CORE_OFF = 2'b00,
    CORE_SOFT = 2'b01,
    CORE_RUN = 2'b11
  } core_state_t;

endpackage

// >>> hw/efuse_and_core_rail_control.sv
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "efuse_core_consts.svh"
// Functional notes
// - 12V switch off at reset, pin-gated turn-on
// - 12V over-voltage clamps output, sets flag
// - over-temperature shutdown, auto restart when cool
// - 12V short limit held until status write
// - 5V switch off at reset, pin-gated turn-on
// - 5V over-voltage clamps output, sets flag
// - reverse current opens 5V, restart when clear
// - open-drain indicator while 5V switch blocked
// - 5V short limit held until 3.3V good
// - current monitors disabled until firmware enables
// - switch or regulator fault clears monitor enable
// - two selectable current monitor gains
// - core power-good low when output too low
// - core follows enable pin; low clears bits
// - disable/hold writable only while unlocked
// - writing other registers clears unlock
// - hold bit freezes core power-good pin
// - disable bit shuts core regulator off
// - re-enable restarts; soft-start end clears hold
// - six-bit core voltage code, default 100010
// - power-disable pin high means power off
// - firmware enable bit honoured only when gated
// - status latches first fault, write clears
module efuse_and_core_rail_control
  import efuse_core_pkg::*;
#(
  parameter logic [7:0] ID_MAIN = 8'h5a, // arbitrary value
  parameter logic [7:0] ID_AUX = 8'ha5, // arbitrary value
  parameter int ADDR_W = 5
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fuse_sense_t sense12,
  input wire fuse_sense_t sense5,
  input wire logic reverseOver5,
  input wire logic reverseZero5,
  input wire logic powerGood33,
  input wire rail_sense_t railSense,
  input wire logic powerDisablePin,
  input wire logic firmwareGatePin,
  input wire logic coreRailEnablePin,
  input wire logic coreSoftStartDone,
  input wire logic coreUnderTarget,
  output fuse_ctrl_t ctrl12,
  output fuse_ctrl_t ctrl5,
  output logic reverseBlockIndicatorOut,
  output logic reverseBlockIndicatorOe,
  output logic monitorEnable,
  output logic monitorGain,
  output logic coreRegulatorOn,
  output logic corePowerGoodOut,
  output logic corePowerGoodOe,
  output logic [5:0] coreVoltageSelect,
  output logic [10:0] coreTargetMv,
  output logic [4:0] auxVoltageSelect,
  output logic auxPwmMode,
  output logic corePwmMode,
  output logic deglitchMode
);

  if (ADDR_W < 5 || ADDR_W > 16) begin
    $error("ADDR_W must be 5..16");
  end

  function automatic logic [10:0] code_to_mv(input logic [5:0] code);
    code_to_mv = `CORE_MV_BASE + `CORE_MV_STEP * {5'h0, code};
  endfunction

  function automatic logic word_mapped(input logic [ADDR_W-1:0] a);
    word_mapped = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] <= (ADDR_W-2)'(`IDX_LAST));
  endfunction

  // apb decode; zero wait states, every access answered in its first access cycle
  logic access;
  logic wrEn;
  logic [2:0] idx;
  logic mapped;
  assign access = psel & penable;
  assign idx = paddr[4:2];
  assign mapped = word_mapped(paddr);
  assign wrEn = access & pwrite & mapped & pstrb[0];
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  logic wrCoreVsel;
  logic wrAuxVsel;
  logic wrControl;
  logic wrStatusA;
  logic wrStatusB;
  assign wrCoreVsel = wrEn && idx == `IDX_CORE_VSEL;
  assign wrAuxVsel = wrEn && idx == `IDX_AUX_VSEL;
  assign wrControl = wrEn && idx == `IDX_CONTROL;
  assign wrStatusA = wrEn && idx == `IDX_STATUS_A;
  assign wrStatusB = wrEn && idx == `IDX_STATUS_B;

  // register state
  logic [5:0] coreVsel;
  logic [4:0] auxVsel;
  logic unlock;
  logic fwPowerEn;
  logic monGain;
  logic auxPwm;
  logic corePwm;
  logic deglitch;
  logic monEn;
  logic monHold;
  logic coreDis;
  logic [7:0] statusA;
  logic [7:0] statusB;

  // fuse and core state
  logic otLatch12;
  logic otLatch5;
  logic reverseBlocked;
  logic shortLim12;
  logic shortLim5;
  logic pgHeld;
  logic softDonePrev;
  core_state_t coreState;
  core_state_t next_coreState;

  logic powerAllowed;
  logic next_on12;
  logic next_on5;
  logic faultOff;
  logic softDoneRise;
  logic pgLive;

  // pin high disables; bit only counts while the gate pin is high
  assign powerAllowed = ~powerDisablePin & (~firmwareGatePin | fwPowerEn);
  assign next_on12 = sense12.inputOk & powerAllowed & ~otLatch12 & ~sense12.overTemp;
  assign next_on5 = sense5.inputOk & powerAllowed & ~otLatch5 & ~sense5.overTemp
                  & ~reverseBlocked & ~reverseOver5;
  assign faultOff = sense12.overTemp | sense5.overTemp | reverseOver5
                  | railSense.overCurrent33 | railSense.overCurrent09;
  assign softDoneRise = coreSoftStartDone & ~softDonePrev;
  assign pgLive = (coreState == CORE_RUN) & ~coreUnderTarget;

  // voltage selects
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      coreVsel <= `RST_CORE_VSEL;
      auxVsel <= `RST_AUX_VSEL;
    end else begin
      if (wrCoreVsel) begin
        coreVsel <= pwdata[5:0];
      end
      if (wrAuxVsel) begin
        auxVsel <= pwdata[4:0];
      end
    end
  end

  // unlock bit: loaded from bit 5 of an aux select register write, lost on any other write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      unlock <= 1'b0;
    end else if (wrAuxVsel) begin
      unlock <= pwdata[`AUX_UNLOCK_BIT];
    end else if (wrEn) begin
      unlock <= 1'b0;
    end
  end

  // plain control bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fwPowerEn <= 1'b0;
      monGain <= 1'b0;
      auxPwm <= 1'b0;
      corePwm <= 1'b0;
      deglitch <= 1'b0;
    end else if (wrControl) begin
      fwPowerEn <= pwdata[`CTL_FW_POWER_EN];
      monGain <= pwdata[`CTL_MON_GAIN];
      auxPwm <= pwdata[`CTL_AUX_PWM];
      corePwm <= pwdata[`CTL_CORE_PWM];
      deglitch <= pwdata[`CTL_DEGLITCH];
    end
  end

  // monitor enable; a fault beats a firmware set in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      monEn <= 1'b0;
    end else if (faultOff) begin
      monEn <= 1'b0;
    end else if (wrControl) begin
      monEn <= pwdata[`CTL_MON_EN];
    end
  end

  // keyed disable bit; pin low forces it clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      coreDis <= 1'b0;
    end else if (~coreRailEnablePin) begin
      coreDis <= 1'b0;
    end else if (wrControl && unlock) begin
      coreDis <= pwdata[`CTL_CORE_DIS];
    end
  end

  // keyed hold bit; cleared by pin low or end of soft start
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      monHold <= 1'b0;
    end else if (~coreRailEnablePin) begin
      monHold <= 1'b0;
    end else if (wrControl && unlock) begin
      monHold <= pwdata[`CTL_MON_HOLD];
    end else if (softDoneRise) begin
      monHold <= 1'b0;
    end
  end

  // core sequence
  always_comb begin
    next_coreState = coreState;
    case (coreState)
      CORE_OFF: begin
        if (coreRailEnablePin && !coreDis) begin
          next_coreState = CORE_SOFT;
        end
      end
      CORE_SOFT: begin
        if (!coreRailEnablePin || coreDis) begin
          next_coreState = CORE_OFF;
        end else if (softDoneRise) begin
          next_coreState = CORE_RUN;
        end
      end
      CORE_RUN: begin
        if (!coreRailEnablePin || coreDis) begin
          next_coreState = CORE_OFF;
        end
      end
      default: begin
        next_coreState = CORE_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      coreState <= CORE_OFF;
      softDonePrev <= 1'b0;
    end else begin
      coreState <= next_coreState;
      softDonePrev <= coreSoftStartDone;
    end
  end

  // power-good follows the output unless held
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pgHeld <= 1'b0;
    end else if (!monHold) begin
      pgHeld <= pgLive;
    end
  end

  // thermal latches restart once cooled below hysteresis
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      otLatch12 <= 1'b0;
      otLatch5 <= 1'b0;
    end else begin
      if (sense12.overTemp) begin
        otLatch12 <= 1'b1;
      end else if (sense12.tempCool) begin
        otLatch12 <= 1'b0;
      end
      if (sense5.overTemp) begin
        otLatch5 <= 1'b1;
      end else if (sense5.tempCool) begin
        otLatch5 <= 1'b0;
      end
    end
  end

  // reverse block released only with zero current and startup met
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reverseBlocked <= 1'b0;
    end else if (reverseOver5) begin
      reverseBlocked <= 1'b1;
    end else if (reverseZero5 && sense5.inputOk && powerAllowed) begin
      reverseBlocked <= 1'b0;
    end
  end

  // short limits; detection wins over the clearing event
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shortLim12 <= 1'b0;
      shortLim5 <= 1'b0;
    end else begin
      if (sense12.shortDetect) begin
        shortLim12 <= 1'b1;
      end else if (wrStatusA || wrStatusB) begin
        shortLim12 <= 1'b0;
      end
      if (sense5.shortDetect) begin
        shortLim5 <= 1'b1;
      end else if (powerGood33) begin
        shortLim5 <= 1'b0;
      end
    end
  end

  // status: first fault latched, later ones ignored until a write clears
  logic [7:0] eventsA;
  logic [7:0] eventsB;
  logic frozen;
  assign eventsA = {sense12.underVoltage, sense5.underVoltage,
                    railSense.underVoltage33, railSense.underVoltage09,
                    sense12.overTemp, sense5.overTemp, sense12.tempWarn, sense5.tempWarn};
  assign eventsB = {sense12.overCurrent, sense5.overCurrent,
                    railSense.overCurrent33, railSense.overCurrent09,
                    powerDisablePin, 1'b0, sense12.overVoltage, sense5.overVoltage};
  assign frozen = (|statusA) | (|statusB);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      statusA <= 8'h00;
      statusB <= 8'h00;
    end else if (wrStatusA || wrStatusB) begin
      // an event in the clearing cycle becomes the new first fault
      statusA <= eventsA;
      statusB <= eventsB;
    end else if (!frozen) begin
      statusA <= eventsA;
      statusB <= eventsB;
    end
  end

  // outputs from flops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl12 <= '0;
      ctrl5 <= '0;
      coreRegulatorOn <= 1'b0;
      coreTargetMv <= `RST_CORE_MV;
    end else begin
      ctrl12.on <= next_on12;
      ctrl12.clamp <= sense12.overVoltage;
      ctrl12.shortLimit <= shortLim12 | sense12.shortDetect;
      ctrl5.on <= next_on5;
      ctrl5.clamp <= sense5.overVoltage;
      ctrl5.shortLimit <= shortLim5 | sense5.shortDetect;
      coreRegulatorOn <= (next_coreState != CORE_OFF);
      coreTargetMv <= code_to_mv(coreVsel);
    end
  end

  // open-drain pins: drive low only
  assign reverseBlockIndicatorOut = 1'b0;
  assign reverseBlockIndicatorOe = reverseBlocked;
  assign corePowerGoodOut = 1'b0;
  assign corePowerGoodOe = ~pgHeld;

  assign monitorEnable = monEn;
  assign monitorGain = monGain;
  assign coreVoltageSelect = coreVsel;
  assign auxVoltageSelect = auxVsel;
  assign auxPwmMode = auxPwm;
  assign corePwmMode = corePwm;
  assign deglitchMode = deglitch;

  // read mux
  always_comb begin
    prdata = 32'h0;
    if (access && !pwrite && mapped) begin
      case (idx)
        `IDX_ID_MAIN: prdata[7:0] = ID_MAIN;
        `IDX_ID_AUX: prdata[7:0] = ID_AUX;
        `IDX_CORE_VSEL: prdata[7:0] = {2'b00, coreVsel};
        `IDX_AUX_VSEL: prdata[7:0] = {2'b00, unlock, auxVsel};
        `IDX_CONTROL: prdata[7:0] = {fwPowerEn, monGain, auxPwm, corePwm,
                                     deglitch, monEn, monHold, coreDis};
        `IDX_STATUS_A: prdata[7:0] = statusA;
        `IDX_STATUS_B: prdata[7:0] = statusB;
        default: prdata = 32'h0;
      endcase
    end
  end
endmodule

// >>> tb/efuse_core_checker.sv
`timescale 1ns/1ns
module efuse_core_checker
  import efuse_core_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [4:0] paddr,
  input wire logic [3:0] pstrb,
  input wire fuse_sense_t sense12,
  input wire fuse_sense_t sense5,
  input wire logic reverseOver5,
  input wire logic powerGood33,
  input wire logic powerDisablePin,
  input wire logic coreRailEnablePin,
  input wire fuse_ctrl_t ctrl12,
  input wire fuse_ctrl_t ctrl5,
  input wire logic reverseBlockIndicatorOe,
  input wire logic monitorEnable,
  input wire logic coreRegulatorOn,
  input wire logic corePowerGoodOe,
  input wire logic [5:0] coreVoltageSelect,
  input wire logic [10:0] coreTargetMv
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic statusWr;
  assign statusWr = psel && penable && pwrite && pstrb[0] && paddr inside {5'h14, 5'h18};
  sequence s_pin_low2;
    !coreRailEnablePin [*2];
  endsequence
  a_clamp_12v: assert property (sense12.overVoltage |=> ctrl12.clamp)
    else $error("12V clamp missing");
  a_thermal_off: assert property (sense12.overTemp |=> !ctrl12.on)
    else $error("12V switch on while hot");
  a_short12_hold: assert property ($fell(ctrl12.shortLimit) |-> $past(statusWr, 2))
    else $error("12V short limit dropped without status write");
  a_reverse_open: assert property (reverseOver5 |=> !ctrl5.on && reverseBlockIndicatorOe)
    else $error("5V switch not opened on reverse current");
  a_short5_hold: assert property ($fell(ctrl5.shortLimit) |-> $past(powerGood33, 2))
    else $error("5V short limit dropped without 3.3V good");
  a_mon_fault_clear: assert property ((sense12.overTemp || reverseOver5) |=> !monitorEnable)
    else $error("monitor still enabled after fault");
  a_pg_pin_low: assert property (s_pin_low2 |=> corePowerGoodOe)
    else $error("core power good not pulled low");
  a_core_pin_off: assert property (!coreRailEnablePin |=> !coreRegulatorOn)
    else $error("core regulator on with pin low");
  a_vsel_map: assert property ($stable(coreVoltageSelect) |->
    coreTargetMv == 11'h302 + 11'h5 * coreVoltageSelect)
    else $error("core target voltage mismatch");
  a_pdis_off: assert property (powerDisablePin |=> !ctrl12.on && !ctrl5.on)
    else $error("switch on while power disabled");
endmodule
bind efuse_and_core_rail_control efuse_core_checker i_efuse_core_checker (.*);

// >>> tb/efuse_host.sv
`timescale 1ns/1ns
module efuse_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [4:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 5'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
  end
  task automatic xfer(input logic w, input logic [2:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [2:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    logic e;
    xfer(1'h1, idx, wd, d, e);
  endtask
  // key first, since any other write drops it again
  task automatic keyed(input logic [7:0] ctl);
    wr(3'h3, 8'h33);
    wr(3'h4, ctl);
  endtask
endmodule

// >>> tb/efuse_and_core_rail_control_tb.sv
`timescale 1ns/1ns
module efuse_and_core_rail_control_tb
  import efuse_core_pkg::*;
;
  localparam logic [7:0] IDM = 8'h5a; // arbitrary value
  localparam logic [7:0] IDA = 8'ha5; // arbitrary value
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [4:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  fuse_sense_t sense12, sense5;
  rail_sense_t railSense;
  fuse_ctrl_t ctrl12, ctrl5;
  logic reverseOver5, reverseZero5, powerGood33, powerDisablePin, firmwareGatePin;
  logic coreRailEnablePin, coreSoftStartDone, coreUnderTarget;
  logic reverseBlockIndicatorOut, reverseBlockIndicatorOe, monitorEnable, monitorGain;
  logic coreRegulatorOn, corePowerGoodOut, corePowerGoodOe, auxPwmMode, corePwmMode, deglitchMode;
  logic [5:0] coreVoltageSelect;
  logic [10:0] coreTargetMv;
  logic [4:0] auxVoltageSelect;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  efuse_and_core_rail_control #(.ID_MAIN(IDM), .ID_AUX(IDA)) i_efuse_and_core_rail_control (.*);
  efuse_host i_efuse_host (.*);
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [2:0] idx, input logic [31:0] exp, input logic eexp);
    logic [31:0] d;
    logic e;
    i_efuse_host.xfer(1'h0, idx, 8'h0, d, e);
    chk(d, exp);
    chk(e, eexp);
  endtask
  // outputs are registered, so give every cause a few edges to land
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic ssd();
    @(posedge clk) coreSoftStartDone <= 1'h1;
    @(posedge clk) coreSoftStartDone <= 1'h0;
    settle();
  endtask
  initial begin
    logic [7:0] rst[7];
    sys_rst = 1'h1;
    sense12 = '0;
    sense12.inputOk = 1'h1;
    sense5 = sense12;
    railSense = '0;
    {reverseOver5, powerGood33, powerDisablePin, firmwareGatePin} = 4'h0;
    {reverseZero5, coreRailEnablePin, coreSoftStartDone, coreUnderTarget} = 4'hc;
    rst = '{IDM, IDA, 8'h22, 8'h13, 8'h0, 8'h0, 8'h0};
    repeat (20) @(posedge clk);
    sys_rst <= 1'h0;
    for (int i = 0; i < 7; i++) rdchk(i[2:0], {24'h0, rst[i]}, 1'h0);
    rdchk(3'h7, 32'h0, 1'h1);
    chk(monitorEnable, 1'h0);
    chk({auxVoltageSelect, reverseBlockIndicatorOut, corePowerGoodOut}, 7'h4c);
    ssd();
    chk(corePowerGoodOe, 1'h0);
    @(posedge clk) sense12.shortDetect <= 1'h1;
    @(posedge clk) sense12.shortDetect <= 1'h0;
    sense12.overVoltage <= 1'h1;
    settle();
    rdchk(3'h6, 32'h2, 1'h0);
    chk(ctrl12.clamp, 1'h1);
    @(posedge clk) sense5.overVoltage <= 1'h1;
    settle();
    chk(ctrl5.clamp, 1'h1);
    rdchk(3'h6, 32'h2, 1'h0);
    @(posedge clk) {sense12.overVoltage, sense5.overVoltage} <= 2'h0;
    settle();
    chk(ctrl12.shortLimit, 1'h1);
    i_efuse_host.wr(3'h5, 8'h0);
    settle();
    chk(ctrl12.shortLimit, 1'h0);
    rdchk(3'h6, 32'h0, 1'h0);
    i_efuse_host.wr(3'h4, 8'h1);
    settle();
    chk(coreRegulatorOn, 1'h1);
    i_efuse_host.keyed(8'h1);
    settle();
    chk(coreRegulatorOn, 1'h0);
    i_efuse_host.wr(3'h4, 8'h0);
    i_efuse_host.wr(3'h3, 8'h33);
    i_efuse_host.wr(3'h2, 8'h22);
    i_efuse_host.wr(3'h4, 8'h0);
    settle();
    chk(coreRegulatorOn, 1'h0);
    i_efuse_host.keyed(8'h0);
    settle();
    chk(coreRegulatorOn, 1'h1);
    ssd();
    i_efuse_host.keyed(8'h2);
    @(posedge clk) coreUnderTarget <= 1'h1;
    settle();
    chk(corePowerGoodOe, 1'h0);
    @(posedge clk) coreRailEnablePin <= 1'h0;
    settle();
    rdchk(3'h4, 32'h0, 1'h0);
    chk(corePowerGoodOe, 1'h1);
    @(posedge clk) {coreRailEnablePin, coreUnderTarget} <= 2'h2;
    ssd();
    i_efuse_host.keyed(8'h3);
    i_efuse_host.keyed(8'h2);
    settle();
    chk(coreRegulatorOn, 1'h1);
    ssd();
    rdchk(3'h4, 32'h0, 1'h0);
    @(posedge clk) coreUnderTarget <= 1'h1;
    settle();
    chk(corePowerGoodOe, 1'h1);
    @(posedge clk) coreUnderTarget <= 1'h0;
    settle();
    chk(corePowerGoodOe, 1'h0);
    i_efuse_host.wr(3'h4, 8'h7c);
    settle();
    chk({monitorEnable, monitorGain, auxPwmMode, corePwmMode, deglitchMode}, 5'h1f);
    @(posedge clk) {reverseOver5, reverseZero5} <= 2'h2;
    settle();
    chk({monitorEnable, ctrl5.on, reverseBlockIndicatorOe}, 3'h1);
    @(posedge clk) reverseOver5 <= 1'h0;
    settle();
    chk(ctrl5.on, 1'h0);
    @(posedge clk) reverseZero5 <= 1'h1;
    settle();
    chk({ctrl5.on, reverseBlockIndicatorOe}, 2'h2);
    i_efuse_host.wr(3'h4, 8'h04);
    settle();
    chk(monitorEnable, 1'h1);
    @(posedge clk) railSense.overCurrent09 <= 1'h1;
    settle();
    chk(monitorEnable, 1'h0);
    @(posedge clk) railSense.overCurrent09 <= 1'h0;
    rdchk(3'h6, 32'h10, 1'h0);
    @(posedge clk) sense12.overTemp <= 1'h1;
    settle();
    @(posedge clk) sense12.overTemp <= 1'h0;
    settle();
    chk(ctrl12.on, 1'h0);
    @(posedge clk) sense12.tempCool <= 1'h1;
    settle();
    chk(ctrl12.on, 1'h1);
    @(posedge clk) sense5.shortDetect <= 1'h1;
    @(posedge clk) sense5.shortDetect <= 1'h0;
    settle();
    chk(ctrl5.shortLimit, 1'h1);
    @(posedge clk) powerGood33 <= 1'h1;
    settle();
    chk(ctrl5.shortLimit, 1'h0);
    i_efuse_host.wr(3'h2, 8'h3f);
    settle();
    chk({coreVoltageSelect, coreTargetMv}, {6'h3f, 11'h43d});
    i_efuse_host.wr(3'h2, 8'h0);
    settle();
    chk(coreTargetMv, 11'h302);
    @(posedge clk) firmwareGatePin <= 1'h1;
    settle();
    chk({ctrl12.on, ctrl5.on}, 2'h0);
    i_efuse_host.wr(3'h4, 8'h80);
    settle();
    chk({ctrl12.on, ctrl5.on}, 2'h3);
    @(posedge clk) powerDisablePin <= 1'h1;
    settle();
    chk({ctrl12.on, ctrl5.on}, 2'h0);
    tally_and_finish();
  end
endmodule
